//--- core/tcrf_cmp.sv
// Threshold and range comparator for cold-junction and thermocouple temperatures.
`timescale 1ns/10ps
module tcrf_cmp (
	// Values, limits and findings
	tcrf_cond_if.cmp c
);
	import tcrf_pkg::*;

	logic [15:0] cj16;
	logic [15:0] floor_v;

	assign cj16 = {{2{c.cj[CJ_W-1]}}, c.cj};

	always_comb begin
		floor_v = CJ_FLOOR_STD;
		if (c.tc_type == TYPE_B) begin
			floor_v = CJ_FLOOR_B;
		end else if (c.tc_type == TYPE_R || c.tc_type == TYPE_S) begin
			floor_v = CJ_FLOOR_RS;
		end
	end

	always_comb begin
		c.hit = BYTE_RST;
		c.hit[FLG_COLD_JUNCTION_RANGE_FLAG] = $signed(cj16) < $signed(floor_v) ||
			$signed(cj16) > $signed(COLD_JUNCTION_RANGE_FLAG_TOP);
		c.hit[FLG_CJ_HIGH] = $signed(c.cj) > $signed({c.cj_hi_thr, 6'h00});
		c.hit[FLG_CJ_LOW] = $signed(c.cj) < $signed({c.cj_lo_thr, 6'h00});
		c.hit[FLG_TC_HIGH] = $signed(c.tc) > $signed({c.tc_hi_thr, 3'h0});
		c.hit[FLG_TC_LOW] = $signed(c.tc) < $signed({c.tc_lo_thr, 3'h0});
	end
endmodule

//--- core/tcrf_cond_if.sv
// Interface carrying temperatures and limits to the comparator and its findings back.
`timescale 1ns/10ps
interface tcrf_cond_if;
	logic [13:0] cj;
	logic [18:0] tc;
	logic [7:0]  cj_hi_thr;
	logic [7:0]  cj_lo_thr;
	logic [15:0] tc_hi_thr;
	logic [15:0] tc_lo_thr;
	logic [3:0]  tc_type;
	logic [7:0]  hit;
	modport core (output cj, tc, cj_hi_thr, cj_lo_thr, tc_hi_thr, tc_lo_thr, tc_type, input hit);
	modport cmp (input cj, tc, cj_hi_thr, cj_lo_thr, tc_hi_thr, tc_lo_thr, tc_type, output hit);
endinterface

//--- core/tcrf_evt_sync.sv
// Toggle synchroniser that turns a far-domain toggle into a one-cycle pulse.
`timescale 1ns/10ps
module tcrf_evt_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Toggle from the link domain
	input  wire logic tgl,
	// Event pulse
	output logic      pulse
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Only the second and third stages feed the edge detect, never the first.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= tgl;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign pulse = s2_q ^ s3_q;
endmodule

//--- core/tcrf_pkg.sv
// Package holding register map, field layout, limits and helpers of the thermocouple result block.
package tcrf_pkg;

	// Field widths.
	localparam int CJ_W    = 14;
	localparam int CJ_LO_W = 6;
	localparam int TC_W    = 19;
	localparam int TC_LO_W = 3;
	localparam int IMG_W   = 48;

	// Register offsets on the serial port.
	localparam logic [6:0] ADDR_CJ_HI = 7'h0A;
	localparam logic [6:0] ADDR_CJ_LO = 7'h0B;
	localparam logic [6:0] ADDR_TC_HI = 7'h0C;
	localparam logic [6:0] ADDR_TC_MD = 7'h0D;
	localparam logic [6:0] ADDR_TC_LO = 7'h0E;
	localparam logic [6:0] ADDR_FLAGS = 7'h0F;

	// Fault status bit positions.
	localparam int FLG_COLD_JUNCTION_RANGE_FLAG = 7;
	localparam int FLG_THERMOCOUPLE_RANGE_FLAG = 6;
	localparam int FLG_CJ_HIGH  = 5;
	localparam int FLG_CJ_LOW   = 4;
	localparam int FLG_TC_HIGH  = 3;
	localparam int FLG_TC_LOW   = 2;
	localparam int FLG_VOLT     = 1;
	localparam int FLG_OPEN     = 0;
	localparam int MASK_W       = 6;

	// Reset values.
	localparam logic [7:0]       BYTE_RST = 8'h00;
	localparam logic [IMG_W-1:0] IMG_RST  = 48'h0000_0000_0000;

	// Cold-junction limits in units of 2^-6 degree, sixteen bits signed.
	localparam logic [15:0] CJ_SAT_MAX   = 16'h1FFF;
	localparam logic [15:0] CJ_SAT_MIN   = 16'hF000;
	localparam logic [15:0] COLD_JUNCTION_RANGE_FLAG_TOP = 16'h1F40;
	localparam logic [15:0] CJ_FLOOR_STD = 16'hF240;
	localparam logic [15:0] CJ_FLOOR_RS  = 16'hF380;
	localparam logic [15:0] CJ_FLOOR_B   = 16'h0000;

	// Thermocouple type codes.
	localparam logic [3:0] TYPE_B = 4'h0;
	localparam logic [3:0] TYPE_R = 4'h5;
	localparam logic [3:0] TYPE_S = 4'h6;

	// Serial framing.
	localparam logic [2:0] BIT_LAST  = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;

	// Sums measured temperature and offset, then clamps to the legal span.
	function automatic logic [CJ_W-1:0] cj_sum_sat(logic [CJ_W-1:0] meas, logic [7:0] ofs);
		logic signed [15:0] s;
		s = $signed({{2{meas[CJ_W-1]}}, meas}) + $signed({{6{ofs[7]}}, ofs, 2'h0});
		if (s > $signed(CJ_SAT_MAX)) begin
			return CJ_SAT_MAX[CJ_W-1:0];
		end else if (s < $signed(CJ_SAT_MIN)) begin
			return CJ_SAT_MIN[CJ_W-1:0];
		end
		return s[CJ_W-1:0];
	endfunction

	// Packs the readable bytes, first offset in the top byte; don't-care bits read zero.
	function automatic logic [IMG_W-1:0] pack_image(logic [CJ_W-1:0] cj, logic [TC_W-1:0] tc,
			logic [7:0] st);
		return {cj, 2'h0, tc, 5'h00, st};
	endfunction

	// Selects one byte of the image by offset; other offsets read zero.
	function automatic logic [7:0] img_byte(logic [6:0] a, logic [IMG_W-1:0] img);
		if (a == ADDR_CJ_HI) begin
			return img[47:40];
		end else if (a == ADDR_CJ_LO) begin
			return img[39:32];
		end else if (a == ADDR_TC_HI) begin
			return img[31:24];
		end else if (a == ADDR_TC_MD) begin
			return img[23:16];
		end else if (a == ADDR_TC_LO) begin
			return img[15:8];
		end else if (a == ADDR_FLAGS) begin
			return img[7:0];
		end
		return BYTE_RST;
	endfunction

endpackage

//--- core/tcrf_top.sv
// Result and fault status registers of a thermocouple converter behind a serial port.
`timescale 1ns/10ps

// Behaviour
// - Sensor enabled: cold-junction bytes read-only, measured value plus offset.
// - Sensor enabled: reading either cold-junction byte returns data ready high.
// - Sensor disabled: cold-junction bytes writable, keep last result until written.
// - Cold-junction value clamps to its top and to minus 64 degrees.
// - Cold-junction value is two's complement, low two bits read zero.
// - Thermocouple result is 19 bits signed over three bytes, rest reads zero.
// - Thermocouple bytes load the linearised, compensated temperature.
// - Status bits: Cold_junction_range_flag 7, Thermocouple_range_flag 6, limits 5..2, voltage 1, open 0.
// - Comparator mode: each status bit follows its condition.
// - Interrupt mode: bits latch until clear, and set again if condition persists.
// - Cold-junction range flag uses the per-type normal span.
// - Thermocouple range flag from hot junction; host ignores it in voltage mode.
// - Cold-junction high flag when strictly above its limit; fault unless masked.
// - Cold-junction low flag when strictly below its limit; fault unless masked.
// - Thermocouple high flag when strictly above its limit; fault unless masked.
// - Thermocouple low flag when strictly below its limit; fault unless masked.
// - Voltage fault flag when input negative or above supply; fault unless masked.
// - Voltage fault halts conversions, other detection, and comparator clearing.
// - Open-circuit flag when thermocouple broken; fault unless masked.
// - Mask bit zero lets a source drive fault, one suppresses it.
module tcrf_top (
	// System clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	// Serial register port
	input  wire logic                      sclk,
	input  wire logic                      cs_n,
	input  wire logic                      mosi,
	output logic                           miso,
	output logic                           miso_oe_n,
	// Conversion engine
	input  wire logic                      conv_valid,
	input  wire logic [tcrf_pkg::CJ_W-1:0] cj_meas,
	input  wire logic [tcrf_pkg::TC_W-1:0] tc_lin,
	input  wire logic                      thermocouple_range_flag_cond,
	input  wire logic                      volt_fault_cond,
	input  wire logic                      open_cond,
	// Configuration
	input  wire logic                      cj_sensor_en,
	input  wire logic                      fault_intr_mode,
	input  wire logic                      fault_clear,
	input  wire logic [7:0]                cold_junction_offset,
	input  wire logic [3:0]                tc_type,
	input  wire logic [tcrf_pkg::MASK_W-1:0] fault_mask,
	input  wire logic [7:0]                cj_hi_thr,
	input  wire logic [7:0]                cj_lo_thr,
	input  wire logic [15:0]               tc_hi_thr,
	input  wire logic [15:0]               tc_lo_thr,
	// Status pins and compensation value
	output logic                           data_ready_n,
	output logic                           fault_n,
	output logic [tcrf_pkg::CJ_W-1:0]      cj_value
);
	import tcrf_pkg::*;

	tcrf_cond_if cond ();

	// Link domain state.
	logic [2:0]       bit_q;
	logic             hdr_q;
	logic             wr_q;
	logic [6:0]       addr_q;
	logic [6:0]       sh_q;
	logic [7:0]       out_q;
	logic             wr_tgl_q;
	logic [6:0]       wr_addr_q;
	logic [7:0]       wr_data_q;
	logic             rd_tgl_q;

	// System domain state.
	logic             cs_s1_q;
	logic             cs_s2_q;
	logic [CJ_W-1:0]  cj_q;
	logic [TC_W-1:0]  tc_q;
	logic [7:0]       fault_flags_q;
	logic [7:0]       fault_flags_d;
	logic [7:0]       hold_q;
	logic [7:0]       raw_cond;
	logic [7:0]       cond_eff;
	logic [IMG_W-1:0] img_q;
	logic             data_ready_n_n_q;
	logic             fault_n_q;
	logic             wr_p;
	logic             rd_p;
	logic             load;

	// Frame counter, header decode and address; cleared at every frame start.
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_q  <= BIT_FIRST;
			hdr_q  <= 1'b1;
			wr_q   <= 1'b0;
			addr_q <= ADDR_CJ_HI;
			sh_q   <= 7'h00;
		end else begin
			bit_q <= bit_q + 3'h1;
			sh_q  <= {sh_q[5:0], mosi};
			if (bit_q == BIT_LAST) begin
				hdr_q <= 1'b0;
				if (hdr_q) begin
					wr_q   <= sh_q[6];
					addr_q <= {sh_q[5:0], mosi};
				end else begin
					addr_q <= addr_q + 7'h01;
				end
			end
		end
	end

	// Write events keep their data stable for a whole byte, long after the toggle is seen.
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_tgl_q  <= 1'b0;
			wr_addr_q <= ADDR_CJ_HI;
			wr_data_q <= BYTE_RST;
		end else if (!cs_n && bit_q == BIT_LAST && !hdr_q && wr_q) begin
			wr_tgl_q  <= ~wr_tgl_q;
			wr_addr_q <= addr_q;
			wr_data_q <= {sh_q, mosi};
		end
	end

	// Read data shifts out on the falling edge, most significant bit first.
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			out_q <= BYTE_RST;
		end else if (bit_q == BIT_FIRST && !hdr_q) begin
			out_q <= img_byte(addr_q, img_q);
		end else begin
			out_q <= {out_q[6:0], 1'b0};
		end
	end

	// Read event for the cold-junction bytes, raised as the byte is loaded.
	always_ff @(negedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_tgl_q <= 1'b0;
		end else if (!cs_n && bit_q == BIT_FIRST && !hdr_q && !wr_q &&
				(addr_q == ADDR_CJ_HI || addr_q == ADDR_CJ_LO)) begin
			rd_tgl_q <= ~rd_tgl_q;
		end
	end

	assign miso = out_q[7];

	// Frame select crosses by two flip-flops and drives the pin enable.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
		end
	end

	assign miso_oe_n = cs_s2_q;

	tcrf_evt_sync u_wr_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.tgl   (wr_tgl_q),
		.pulse (wr_p)
	);

	tcrf_evt_sync u_rd_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.tgl   (rd_tgl_q),
		.pulse (rd_p)
	);

	// A voltage fault stops conversions from landing.
	assign load = conv_valid && !volt_fault_cond;

	// Cold-junction value: measured sum when enabled, host-written when disabled.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cj_q <= '0;
		end else if (cj_sensor_en) begin
			if (load) begin
				cj_q <= cj_sum_sat(cj_meas, cold_junction_offset);
			end
		end else if (wr_p) begin
			if (wr_addr_q == ADDR_CJ_HI) begin
				cj_q[CJ_W-1:CJ_LO_W] <= wr_data_q;
			end else if (wr_addr_q == ADDR_CJ_LO) begin
				cj_q[CJ_LO_W-1:0] <= wr_data_q[7:2];
			end
		end
	end

	// Thermocouple result arrives already linearised and compensated.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tc_q <= '0;
		end else if (load) begin
			tc_q <= tc_lin;
		end
	end

	assign cond.cj        = cj_q;
	assign cond.tc        = tc_q;
	assign cond.cj_hi_thr = cj_hi_thr;
	assign cond.cj_lo_thr = cj_lo_thr;
	assign cond.tc_hi_thr = tc_hi_thr;
	assign cond.tc_lo_thr = tc_lo_thr;
	assign cond.tc_type   = tc_type;

	tcrf_cmp u_cmp (
		.c (cond)
	);

	// Condition vector in status order.
	always_comb begin
		raw_cond               = cond.hit;
		raw_cond[FLG_THERMOCOUPLE_RANGE_FLAG] = thermocouple_range_flag_cond;
		raw_cond[FLG_VOLT]     = volt_fault_cond;
		raw_cond[FLG_OPEN]     = open_cond;
	end

	// Other detections freeze at their last value while the input voltage is bad.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hold_q <= BYTE_RST;
		end else if (!volt_fault_cond) begin
			hold_q <= raw_cond;
		end
	end

	always_comb begin
		cond_eff = raw_cond;
		if (volt_fault_cond) begin
			cond_eff           = hold_q;
			cond_eff[FLG_VOLT] = 1'b1;
		end
	end

	// A condition present in the clear cycle sets its bit again, so no event is lost.
	always_comb begin
		if (fault_intr_mode) begin
			fault_flags_d = fault_flags_q | cond_eff;
			if (fault_clear) begin
				fault_flags_d = cond_eff;
			end
		end else begin
			fault_flags_d = cond_eff;
			if (volt_fault_cond) begin
				fault_flags_d = fault_flags_q | cond_eff;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fault_flags_q <= BYTE_RST;
		end else begin
			fault_flags_q <= fault_flags_d;
		end
	end

	// Unmasked limit, voltage and open faults drive the fault pin low.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fault_n_q <= 1'b1;
		end else begin
			fault_n_q <= ~|(fault_flags_q[MASK_W-1:0] & ~fault_mask);
		end
	end

	assign fault_n = fault_n_q;

	// A new conversion beats a simultaneous read, so a fresh result is never hidden.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			data_ready_n_n_q <= 1'b1;
		end else if (load) begin
			data_ready_n_n_q <= 1'b0;
		end else if (rd_p && cj_sensor_en) begin
			data_ready_n_n_q <= 1'b1;
		end
	end

	assign data_ready_n = data_ready_n_n_q;

	// The image only refreshes between frames; a burst therefore sees one snapshot.
	// The freeze lands two system cycles after the frame starts, before the serial side reads it after the
	// eight-clock address byte, which covers those cycles at any legal serial rate.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			img_q <= IMG_RST;
		end else if (cs_s2_q) begin
			img_q <= pack_image(cj_q, tc_q, fault_flags_q);
		end
	end

	assign cj_value = cj_q;
endmodule

//--- dv/tcrf_host.sv
// Host model that runs frames on the serial register port in its own clock domain.
`timescale 1ns/10ps
module tcrf_host (
	// Serial port
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end
	// Header and four data bytes; sclk stands low between frames, period 30 ns.
	task automatic frame(input logic [7:0] hdr, input logic [31:0] wd, output logic [31:0] rd);
		logic [39:0] sh;
		sh = {hdr, wd};
		rd = 32'h0000_0000;
		cs_n = 1'b0;
		for (int i = 39; i >= 0; i--) begin
			mosi = sh[i];
			#15 sclk = 1'b1;
			if (i < 32) rd = {rd[30:0], miso};
			#15 sclk = 1'b0;
		end
		// A released line shows the inverse of its last bit.
		mosi = ~mosi;
		#15 cs_n = 1'b1;
		#60;
	endtask
endmodule

//--- dv/tcrf_monitor.sv
// Port checker for the thermocouple result and fault status block.
`timescale 1ns/10ps
module tcrf_monitor (
	// Clock and reset
	input wire logic                        clk,
	input wire logic                        rst_b,
	// Watched ports
	input wire logic                        cs_n,
	input wire logic                        conv_valid,
	input wire logic                        open_cond,
	input wire logic                        volt_fault_cond,
	input wire logic                        cj_sensor_en,
	input wire logic                        fault_intr_mode,
	input wire logic                        fault_clear,
	input wire logic [tcrf_pkg::MASK_W-1:0] fault_mask,
	input wire logic                        data_ready_n,
	input wire logic                        fault_n,
	input wire logic [tcrf_pkg::CJ_W-1:0]   cj_value
);
	import tcrf_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_load; conv_valid && !volt_fault_cond |=> !data_ready_n; endproperty
	a_load: assert property (p_load) else $error("load missed ready");
	property p_halt; volt_fault_cond && data_ready_n |=> data_ready_n; endproperty
	a_halt: assert property (p_halt) else $error("load during voltage fault");
	property p_open; (open_cond && !fault_mask[0] && !volt_fault_cond)[*3] |-> !fault_n; endproperty
	a_open: assert property (p_open) else $error("open fault missed");
	property p_volt; (volt_fault_cond && !fault_mask[1])[*3] |-> !fault_n; endproperty
	a_volt: assert property (p_volt) else $error("voltage fault missed");
	property p_mask; (fault_mask == 6'h3F)[*3] |-> fault_n; endproperty
	a_mask: assert property (p_mask) else $error("masked fault shown");
	property p_clr;
		(!fault_intr_mode && !volt_fault_cond && !open_cond && fault_mask == 6'h3E)[*3] |-> fault_n;
	endproperty
	a_clr: assert property (p_clr) else $error("comparator bit stuck");
	property p_latch;
		(fault_intr_mode && !fault_clear && fault_mask == 6'h3E)[*2] ##0 !fault_n |=> !fault_n;
	endproperty
	a_latch: assert property (p_latch) else $error("latched bit lost");
	property p_hold; (cs_n && !cj_sensor_en)[*8] ##0 conv_valid |=> $stable(cj_value); endproperty
	a_hold: assert property (p_hold) else $error("disabled value reloaded");
endmodule

//--- dv/tcrf_top_tb.sv
// Self-checking bench for the thermocouple result and fault status registers.
`timescale 1ns/10ps
module tcrf_top_tb;
	import tcrf_pkg::*;
	localparam int LIMIT = 40000;
	logic clk = 1'b0, rst_b = 1'b0, conv_valid = 1'b0, thermocouple_range_flag_cond = 1'b0;
	logic volt_fault_cond = 1'b0, open_cond = 1'b0, cj_sensor_en = 1'b1;
	logic fault_intr_mode = 1'b0, fault_clear = 1'b0;
	logic [CJ_W-1:0] cj_meas = 14'h0000;
	logic [TC_W-1:0] tc_lin = 19'h00000;
	logic [7:0] cold_junction_offset = 8'h00, cj_hi_thr = 8'h19, cj_lo_thr = 8'h14;
	logic [3:0] tc_type = 4'h3;
	logic [MASK_W-1:0] fault_mask = 6'h3F;
	logic [15:0] tc_hi_thr = 16'h0640, tc_lo_thr = 16'h0500;
	logic sclk, cs_n, mosi, miso, miso_oe_n, data_ready_n, fault_n;
	logic [CJ_W-1:0] cj_value;
	int fail_count = 0, comparisons = 0, cycles = 0;
	always #2 clk = ~clk;
	tcrf_top DUT (.clk, .rst_b, .sclk, .cs_n, .mosi, .miso, .miso_oe_n, .conv_valid, .cj_meas,
		.tc_lin, .thermocouple_range_flag_cond, .volt_fault_cond, .open_cond, .cj_sensor_en, .fault_intr_mode,
		.fault_clear, .cold_junction_offset, .tc_type, .fault_mask, .cj_hi_thr, .cj_lo_thr,
		.tc_hi_thr, .tc_lo_thr, .data_ready_n, .fault_n, .cj_value);
	tcrf_host host (.sclk, .cs_n, .mosi, .miso);
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	// Frames start off the clock edge, 1.7 ns after it, so every frame meets the clock at the same phase.
	task automatic xfer(input logic [7:0] hdr, input logic [31:0] wd, output logic [31:0] d);
		#0.7;
		fork
			host.frame(hdr, wd, d);
			begin
				tick(8);
				chk1("oe", 1'b0, miso_oe_n);
			end
		join
		tick(1);
		chk1("oe", 1'b1, miso_oe_n);
	endtask
	task automatic conv(input logic [CJ_W-1:0] c, input logic [TC_W-1:0] t);
		cj_meas = c;
		tc_lin = t;
		conv_valid = 1'b1;
		tick(1);
		conv_valid = 1'b0;
		tick(3);
	endtask
	task automatic clr;
		fault_clear = 1'b1;
		tick(1);
		fault_clear = 1'b0;
		tick(3);
	endtask
	task automatic lim(input logic [3:0] ty, input logic [2:0] cd, input logic [CJ_W-1:0] c,
			input logic [TC_W-1:0] t, input logic [7:0] e);
		logic [31:0] d;
		tc_type = ty;
		{thermocouple_range_flag_cond, volt_fault_cond, open_cond} = cd;
		conv(c, t);
		xfer(8'h0F, 32'h0, d);
		chk("status", {e, 24'h0}, d);
		chk1("fault", ~|e[5:0], fault_n);
	endtask
	task automatic t_basic;
		logic [31:0] d;
		chk1("ready", 1'b1, data_ready_n);
		xfer(8'h0A, 32'h0, d);
		chk("cj", 32'h0, d);
		xfer(8'h0C, 32'h0, d);
		chk("tc", 32'h0000_0014, d);
		cold_junction_offset = 8'h10;
		conv(14'h0583, 19'h02D05);
		chk1("ready", 1'b0, data_ready_n);
		xfer(8'h0C, 32'h0, d);
		chk("tc", {19'h02D05, 5'h00, 8'h00}, d);
		chk1("ready", 1'b0, data_ready_n);
		xfer(8'h8A, 32'hAAAA_5555, d);
		chk1("ready", 1'b0, data_ready_n);
		xfer(8'h0A, 32'h0, d);
		chk("cj", {14'h05C3, 2'h0, 16'h05A0}, d);
		chk1("ready", 1'b1, data_ready_n);
		fork
			xfer(8'h0C, 32'h0, d);
			begin
				tick(80);
				conv(14'h0583, 19'h02D06);
			end
		join
		chk("snap", {19'h02D05, 5'h00, 8'h00}, d);
		xfer(8'h0E, 32'h0, d);
		chk("low", 32'hC000_0000, d);
		$display("done basic");
	endtask
	task automatic t_sat_dis;
		logic [31:0] d;
		cold_junction_offset = 8'h7F;
		conv(14'h1F00, 19'h02D00);
		xfer(8'h0A, 32'h0, d);
		chk("top", 32'h7FFC_05A0, d);
		cold_junction_offset = 8'h80;
		conv(14'h3000, 19'h02D00);
		xfer(8'h0A, 32'h0, d);
		chk("bottom", 32'hC000_05A0, d);
		cj_sensor_en = 1'b0;
		cold_junction_offset = 8'h00;
		xfer(8'h8A, 32'h1237_5555, d);
		chk("cjv", 32'h0000_048D, {18'h0, cj_value});
		conv(14'h0001, 19'h00008);
		xfer(8'h0A, 32'h0, d);
		chk("cj", 32'h1234_0001, d);
		chk1("ready", 1'b0, data_ready_n);
		cj_sensor_en = 1'b1;
		$display("done sat");
	endtask
	task automatic t_faults;
		logic [31:0] d;
		fault_mask = 6'h00;
		lim(4'h3, 3'h0, 14'h0640, 19'h03200, 8'h00);
		lim(4'h3, 3'h0, 14'h0641, 19'h03201, 8'h28);
		lim(4'h3, 3'h0, 14'h0500, 19'h02800, 8'h00);
		lim(4'h3, 3'h0, 14'h04FF, 19'h027FF, 8'h14);
		lim(4'h3, 3'h0, 14'h3240, 19'h02D00, 8'h10);
		lim(4'h3, 3'h0, 14'h323F, 19'h02D00, 8'h90);
		lim(4'h5, 3'h0, 14'h3300, 19'h02D00, 8'h90);
		lim(4'h6, 3'h0, 14'h3300, 19'h02D00, 8'h90);
		lim(4'h0, 3'h0, 14'h3FFF, 19'h02D00, 8'h90);
		lim(4'h3, 3'h0, 14'h1F41, 19'h02D00, 8'hA0);
		lim(4'h3, 3'h4, 14'h0580, 19'h02D00, 8'h40);
		lim(4'h3, 3'h1, 14'h0580, 19'h02D00, 8'h01);
		lim(4'h3, 3'h0, 14'h0580, 19'h02D00, 8'h00);
		lim(4'h3, 3'h2, 14'h0580, 19'h02D00, 8'h02);
		lim(4'h3, 3'h0, 14'h0580, 19'h02D00, 8'h00);
		fault_mask = 6'h3E;
		fault_intr_mode = 1'b1;
		open_cond = 1'b1;
		tick(3);
		open_cond = 1'b0;
		tick(3);
		xfer(8'h0F, 32'h0, d);
		chk("latched", 32'h0100_0000, d);
		fault_mask = 6'h3F;
		tick(3);
		chk1("fault", 1'b1, fault_n);
		fault_mask = 6'h3E;
		clr();
		xfer(8'h0F, 32'h0, d);
		chk("cleared", 32'h0, d);
		open_cond = 1'b1;
		tick(2);
		clr();
		xfer(8'h0F, 32'h0, d);
		chk("persist", 32'h0100_0000, d);
		open_cond = 1'b0;
		fault_intr_mode = 1'b0;
		tick(4);
		chk1("fault", 1'b1, fault_n);
		$display("done faults");
	endtask
	task automatic t_volt;
		logic [31:0] d;
		fault_mask = 6'h00;
		xfer(8'h0A, 32'h0, d);
		open_cond = 1'b1;
		tick(3);
		volt_fault_cond = 1'b1;
		tick(2);
		open_cond = 1'b0;
		tick(3);
		conv(14'h0600, 19'h03000);
		xfer(8'h0C, 32'h0, d);
		chk("frozen", {19'h02D00, 5'h00, 8'h03}, d);
		chk1("ready", 1'b1, data_ready_n);
		volt_fault_cond = 1'b0;
		tick(3);
		xfer(8'h0F, 32'h0, d);
		chk("resumed", 32'h0, d);
		$display("done volt");
	endtask
	initial begin
		tick(6);
		rst_b = 1'b1;
		tick(4);
		t_basic();
		t_sat_dis();
		t_faults();
		t_volt();
		report_and_stop();
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			report_and_stop();
		end
	end
endmodule
bind tcrf_top tcrf_monitor u_mon (.clk, .rst_b, .cs_n, .conv_valid, .open_cond, .volt_fault_cond,
	.cj_sensor_en, .fault_intr_mode, .fault_clear, .fault_mask, .data_ready_n, .fault_n,
	.cj_value);
